// [rtl/spp_pkg.sv]
// Package for the program message parser: characters, limits, states.
// Assumes one clock domain and a byte stream synchronous to it.
package spp_pkg;

  // ------------------------------------------------------------------
  // Characters
  // ------------------------------------------------------------------
  localparam logic [7:0] CH_NL = 8'h0a;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_CR = 8'h0d;

  // ------------------------------------------------------------------
  // Limits
  // ------------------------------------------------------------------
  localparam int KW_MAX = 12;
  localparam int DEPTH = 6;
  localparam int PARAM_MAX = 16;
  localparam int LVL_W = 3;
  localparam int KW_LEN_W = 4;
  localparam int PRM_LEN_W = 5;
  localparam int SHORT_MAX = 4;
  localparam int SHORT_VOWEL = 3;
  localparam int LONG_MIN = 5;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [LVL_W-1:0] LVL_ROOT = 3'h0;

  typedef enum logic [2:0] {
    SPP_ST_START = 3'b000,
    SPP_ST_KEY = 3'b001,
    SPP_ST_AFTQ = 3'b010,
    SPP_ST_PARAM = 3'b011,
    SPP_ST_SKIP = 3'b100
  } spp_state_t;

endpackage : spp_pkg

// [rtl/spp_kw_check.sv]
// Keyword form checker: decides whether a typed keyword is a legal
// short or long form of any keyword of the command tree.
// Assumes the keyword buffer is upper-cased already.
`timescale 1ns/100ps
module spp_kw_check (
  // Keyword text, last typed letter in the low byte
  input wire logic [8*spp_pkg::KW_MAX-1:0] kw_text,
  input wire logic [spp_pkg::KW_LEN_W-1:0] kw_len,
  // Result
  output logic kw_ok
);

  localparam int NKW = 36;
  localparam logic [8*spp_pkg::KW_MAX-1:0] TREE [NKW] = '{
    "ABORT", "CALIBRATE", "DISPLAY", "INITIATE", "LIST", "MEASURE",
    "OUTPUT", "SOURCE", "STATUS", "SYSTEM", "TRIGGER", "VOLTAGE",
    "CURRENT", "FUNCTION", "LEVEL", "IMMEDIATE", "AMPLITUDE", "TRIGGERED",
    "LIMIT", "HIGH", "MODE", "PROTECTION", "SCALAR", "DC",
    "STATE", "OPERATION", "PRESET", "QUESTIONABLE", "CONDITION", "ENABLE",
    "EVENT", "ERROR", "NEXT", "VERSION", "DATA", "COUNT"};

  function automatic logic [7:0] ch(input logic [8*spp_pkg::KW_MAX-1:0] s,
                                    input int n, input int i);
    ch = (i < n) ? s[8*(n-1-i) +: 8] : 8'h00;
  endfunction : ch

  function automatic int slen(input logic [8*spp_pkg::KW_MAX-1:0] s);
    int n;
    n = 0;
    for (int i = 0; i < spp_pkg::KW_MAX; i++) begin
      if (s[8*i +: 8] != 8'h00) begin
        n = i + 1;
      end
    end
    slen = n;
  endfunction : slen

  function automatic logic is_vowel(input logic [7:0] c);
    is_vowel = (c == 8'h41) || (c == 8'h45) || (c == 8'h49) || (c == 8'h4f) ||
               (c == 8'h55);
  endfunction : is_vowel

  always_comb begin
    int n;
    int sl;
    logic same;
    n = 0;
    sl = 0;
    same = 1'b0;
    kw_ok = 1'b0;
    for (int k = 0; k < NKW; k++) begin
      n = slen(TREE[k]);
      // Short form from long form length and fourth letter
      if (n < spp_pkg::LONG_MIN) begin
        sl = n;
      end else if (is_vowel(ch(TREE[k], n, spp_pkg::SHORT_VOWEL))) begin
        sl = spp_pkg::SHORT_VOWEL;
      end else begin
        sl = spp_pkg::SHORT_MAX;
      end
      // Only exact short or exact long form passes
      if ((int'(kw_len) == n) || (int'(kw_len) == sl)) begin
        same = 1'b1;
        for (int i = 0; i < spp_pkg::KW_MAX; i++) begin
          // Byte i of the buffer is letter kw_len-1-i of the typed word
          if ((i < int'(kw_len)) &&
              (kw_text[8*i +: 8] != ch(TREE[k], n, int'(kw_len) - 1 - i))) begin
            same = 1'b0;
          end
        end
        if (same) begin
          kw_ok = 1'b1;
        end
      end
    end
  end

endmodule : spp_kw_check

// [rtl/spp_parser.sv]
// Program message parser: splits a text byte stream into message
// units, resolves tree level and hands each unit on as one record.
// Assumes bytes arrive as a valid/ready stream on clk_sys.
`timescale 1ns/100ps
module spp_parser (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Byte stream in
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  // Decoded unit out
  output logic unit_valid,
  output logic [spp_pkg::LVL_W-1:0] unit_base,
  output logic [spp_pkg::LVL_W-1:0] unit_depth,
  output logic [8*spp_pkg::KW_MAX*spp_pkg::DEPTH-1:0] unit_path,
  output logic unit_query,
  output logic unit_common,
  output logic unit_src_opt,
  output logic [8*spp_pkg::PARAM_MAX-1:0] unit_param,
  output logic [spp_pkg::PRM_LEN_W-1:0] unit_param_len,
  // Status
  output logic err_pulse,
  output logic err_flag,
  output logic msg_done
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  spp_pkg::spp_state_t state_r;
  spp_pkg::spp_state_t state_nxt;
  logic [8*spp_pkg::KW_MAX-1:0] kw_r;
  logic [spp_pkg::KW_LEN_W-1:0] kw_len_r;
  logic [8*spp_pkg::KW_MAX*spp_pkg::DEPTH-1:0] path_r;
  logic [spp_pkg::LVL_W-1:0] lvl_r;
  logic [spp_pkg::LVL_W-1:0] base_r;
  logic [spp_pkg::LVL_W-1:0] prev_parent_r;
  logic query_r;
  logic common_r;
  logic [8*spp_pkg::PARAM_MAX-1:0] prm_r;
  logic [spp_pkg::PRM_LEN_W-1:0] prm_len_r;
  logic kw_ok;
  logic [7:0] up_char;
  logic is_alpha;
  logic is_term;
  logic take;
  logic kw_end;
  logic kw_bad;
  logic unit_end;
  logic unit_emit;
  logic key_err;
  logic src_hit;
  logic is_digit;
  logic src_short;
  logic src_long;

  // ------------------------------------------------------------------
  // Character classes
  // ------------------------------------------------------------------
  // A byte is taken in every cycle that in_valid is high, so the host is never stalled
  assign in_ready = 1'b1;
  assign take = in_valid;
  assign is_term = (in_data == spp_pkg::CH_NL);
  assign is_digit = (in_data >= 8'h30) && (in_data <= 8'h39);

  // Case folding before matching
  assign is_alpha = ((in_data >= 8'h41) && (in_data <= 8'h5a)) ||
                    ((in_data >= 8'h61) && (in_data <= 8'h7a));
  assign up_char = ((in_data >= 8'h61) && (in_data <= 8'h7a)) ?
                   (in_data - 8'h20) : in_data;

  spp_kw_check u_kw (
    .kw_text(kw_r),
    .kw_len(kw_len_r),
    .kw_ok(kw_ok)
  );

  // Optional source keyword: matches "SOUR" or "SOURCE" at level 0
  assign src_short = (kw_len_r == 4'h4) && (kw_r[31:0] == "SOUR");
  assign src_long = (kw_len_r == 4'h6) && (kw_r[47:0] == "SOURCE");
  assign src_hit = (lvl_r == spp_pkg::LVL_ROOT) && !common_r && (src_short || src_long);

  // A keyword closes on colon, query mark, space, semicolon or terminator
  assign kw_end = (state_r == spp_pkg::SPP_ST_KEY) &&
                  ((in_data == spp_pkg::CH_COLON) || (in_data == spp_pkg::CH_QUERY) ||
                   (in_data == spp_pkg::CH_SPACE) || (in_data == spp_pkg::CH_SEMI) ||
                   is_term);
  assign kw_bad = (kw_len_r == '0) || (!common_r && !kw_ok);
  assign unit_end = (in_data == spp_pkg::CH_SEMI) || is_term;

  // ------------------------------------------------------------------
  // Next state and error detect
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    key_err = 1'b0;
    unit_emit = 1'b0;
    if (take) begin
      unique case (state_r)
        spp_pkg::SPP_ST_START: begin
          if (is_term) begin
            state_nxt = spp_pkg::SPP_ST_START;
          end else if (in_data == spp_pkg::CH_COLON || in_data == spp_pkg::CH_STAR ||
                       is_alpha) begin
            state_nxt = spp_pkg::SPP_ST_KEY;
          end else if (in_data == spp_pkg::CH_SPACE || in_data == spp_pkg::CH_CR) begin
            state_nxt = spp_pkg::SPP_ST_START;
          end else begin
            key_err = 1'b1;
          end
        end
        spp_pkg::SPP_ST_KEY: begin
          if (kw_end) begin
            if (kw_bad) begin
              key_err = 1'b1;
            end else if (in_data == spp_pkg::CH_QUERY) begin
              state_nxt = spp_pkg::SPP_ST_AFTQ;
            end else if (in_data == spp_pkg::CH_SPACE) begin
              state_nxt = spp_pkg::SPP_ST_PARAM;
            end else if (unit_end) begin
              unit_emit = 1'b1;
              state_nxt = spp_pkg::SPP_ST_START;
            end else if (lvl_r == 3'(spp_pkg::DEPTH - 1) || common_r) begin
              key_err = 1'b1;
            end
          end else if (!is_alpha && !is_digit) begin
            key_err = 1'b1;
          end else if (kw_len_r == 4'(spp_pkg::KW_MAX)) begin
            key_err = 1'b1;
          end
        end
        spp_pkg::SPP_ST_AFTQ: begin
          // Query mark only after the last keyword
          if (unit_end) begin
            unit_emit = 1'b1;
            state_nxt = spp_pkg::SPP_ST_START;
          end else if (in_data == spp_pkg::CH_SPACE) begin
            state_nxt = spp_pkg::SPP_ST_PARAM;
          end else begin
            key_err = 1'b1;
          end
        end
        spp_pkg::SPP_ST_PARAM: begin
          if (unit_end) begin
            unit_emit = 1'b1;
            state_nxt = spp_pkg::SPP_ST_START;
          end else if (prm_len_r == 5'(spp_pkg::PARAM_MAX) && in_data != spp_pkg::CH_CR) begin
            key_err = 1'b1;
          end
        end
        spp_pkg::SPP_ST_SKIP: begin
          if (is_term) begin
            state_nxt = spp_pkg::SPP_ST_START;
          end
        end
        default: begin
          state_nxt = spp_pkg::SPP_ST_SKIP;
        end
      endcase
      if (key_err) begin
        state_nxt = is_term ? spp_pkg::SPP_ST_START : spp_pkg::SPP_ST_SKIP;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= spp_pkg::SPP_ST_START;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Keyword buffer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      kw_r <= '0;
      kw_len_r <= '0;
      common_r <= 1'b0;
    end else if (take) begin
      // Letters shift in at the low byte, so the text reads first to last downwards
      if (state_r == spp_pkg::SPP_ST_KEY && !kw_end && (is_alpha || is_digit)) begin
        kw_r <= {kw_r[8*spp_pkg::KW_MAX-9:0], up_char};
        kw_len_r <= kw_len_r + 4'h1;
      end else if (state_r == spp_pkg::SPP_ST_START && in_data == spp_pkg::CH_STAR) begin
        kw_r <= '0;
        kw_len_r <= '0;
        common_r <= 1'b1;
      end else if (state_r == spp_pkg::SPP_ST_START && is_alpha) begin
        kw_r <= {{(8*spp_pkg::KW_MAX-8){1'b0}}, up_char};
        kw_len_r <= 4'h1;
        common_r <= 1'b0;
      end else begin
        kw_r <= '0;
        kw_len_r <= '0;
        if (state_r == spp_pkg::SPP_ST_START) begin
          common_r <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Tree level and path
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lvl_r <= spp_pkg::LVL_ROOT;
      base_r <= spp_pkg::LVL_ROOT;
      prev_parent_r <= spp_pkg::LVL_ROOT;
      path_r <= '0;
    end else if (take) begin
      if (key_err || is_term) begin
        // Terminator or error: next message starts at root
        lvl_r <= spp_pkg::LVL_ROOT;
        base_r <= spp_pkg::LVL_ROOT;
        prev_parent_r <= spp_pkg::LVL_ROOT;
        path_r <= '0;
      end else if (state_r == spp_pkg::SPP_ST_START) begin
        if (in_data == spp_pkg::CH_COLON) begin
          lvl_r <= spp_pkg::LVL_ROOT;
          base_r <= spp_pkg::LVL_ROOT;
          path_r <= '0;
        end else if (is_alpha || in_data == spp_pkg::CH_STAR) begin
          lvl_r <= prev_parent_r;
          base_r <= prev_parent_r;
        end
      end else if (kw_end) begin
        if (src_hit && in_data == spp_pkg::CH_COLON) begin
          lvl_r <= spp_pkg::LVL_ROOT;
        end else begin
          path_r[8*spp_pkg::KW_MAX*lvl_r +: 8*spp_pkg::KW_MAX] <= kw_r;
          if (in_data == spp_pkg::CH_COLON) begin
            lvl_r <= lvl_r + 3'h1;
          end
        end
        if (unit_end || in_data != spp_pkg::CH_COLON) begin
          prev_parent_r <= common_r ? spp_pkg::LVL_ROOT : lvl_r;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Query flag and parameter text
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      query_r <= 1'b0;
      prm_r <= '0;
      prm_len_r <= '0;
    end else if (take) begin
      if (state_r == spp_pkg::SPP_ST_START) begin
        query_r <= 1'b0;
        prm_r <= '0;
        prm_len_r <= '0;
      end else if (kw_end && in_data == spp_pkg::CH_QUERY) begin
        query_r <= 1'b1;
      end else if (state_r == spp_pkg::SPP_ST_PARAM && !unit_end &&
                   in_data != spp_pkg::CH_CR && !key_err) begin
        prm_r <= {prm_r[8*spp_pkg::PARAM_MAX-9:0], in_data};
        prm_len_r <= prm_len_r + 5'h01;
      end
    end
  end

  // ------------------------------------------------------------------
  // Unit record and status outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      unit_valid <= 1'b0;
      unit_base <= spp_pkg::LVL_ROOT;
      unit_depth <= spp_pkg::LVL_ROOT;
      unit_path <= '0;
      unit_query <= 1'b0;
      unit_common <= 1'b0;
      unit_src_opt <= 1'b0;
      unit_param <= '0;
      unit_param_len <= '0;
    end else begin
      unit_valid <= unit_emit;
      if (unit_emit) begin
        unit_base <= base_r;
        unit_depth <= lvl_r + 3'h1;
        unit_path <= path_r;
        // A unit closed straight from a keyword still holds it in the buffer
        if (state_r == spp_pkg::SPP_ST_KEY) begin
          unit_path[8*spp_pkg::KW_MAX*lvl_r +: 8*spp_pkg::KW_MAX] <= kw_r;
        end
        unit_query <= query_r;
        unit_common <= common_r;
        unit_src_opt <= (lvl_r == spp_pkg::LVL_ROOT) && !common_r;
        unit_param <= prm_r;
        unit_param_len <= prm_len_r;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      err_pulse <= 1'b0;
      err_flag <= 1'b0;
      msg_done <= 1'b0;
    end else begin
      err_pulse <= key_err;
      msg_done <= take && is_term;
      // An error on the newline byte itself keeps the flag set
      if (key_err) begin
        err_flag <= 1'b1;
      end else if (take && is_term && state_r != spp_pkg::SPP_ST_SKIP) begin
        err_flag <= 1'b0;
      end
    end
  end

endmodule : spp_parser

// [dv/spp_parser_properties.sv]
// Checker for the program message parser, bound to its ports.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/100ps
module spp_parser_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Byte stream
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  // Decoded unit
  input wire logic unit_valid,
  input wire logic [spp_pkg::LVL_W-1:0] unit_base,
  input wire logic [spp_pkg::LVL_W-1:0] unit_depth,
  input wire logic unit_src_opt,
  // Status
  input wire logic err_pulse,
  input wire logic err_flag,
  input wire logic msg_done
);
  logic first_r;
  logic skip_r;
  logic [spp_pkg::LVL_W-1:0] prev_d_r;

  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ------------------------------------------------------------------
  // Helper state: first unit of a message, discard span, last depth
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || msg_done) begin
      first_r <= 1'b1;
    end else if (unit_valid) begin
      first_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst || msg_done) begin
      skip_r <= 1'b0;
    end else if (err_pulse) begin
      skip_r <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_d_r <= spp_pkg::LVL_ROOT;
    end else if (unit_valid) begin
      prev_d_r <= unit_depth;
    end
  end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  chk_nl_ends_msg: assert property (
    in_valid && in_data == spp_pkg::CH_NL |=> msg_done) else $error("no done after newline");
  chk_done_cause: assert property (
    msg_done |-> $past(in_valid) && $past(in_data) == spp_pkg::CH_NL)
    else $error("done without newline");
  chk_first_root: assert property (
    unit_valid && first_r |-> unit_base == spp_pkg::LVL_ROOT) else $error("first unit off root");
  chk_resume_level: assert property (
    unit_valid && !first_r |-> unit_base == spp_pkg::LVL_ROOT || unit_base == prev_d_r - 3'h1)
    else $error("unit base not parent level");
  chk_depth_above: assert property (
    unit_valid |-> unit_depth > unit_base) else $error("depth not above base");
  chk_srcopt_root: assert property (
    unit_valid && unit_src_opt |-> unit_base == spp_pkg::LVL_ROOT) else $error("source off root");
  chk_err_sets: assert property (
    err_pulse |-> ##[0:1] err_flag) else $error("error flag not set");
  chk_err_hold: assert property (
    $fell(err_flag) |-> msg_done || $past(msg_done)) else $error("error flag dropped early");
  chk_no_unit_skip: assert property (
    unit_valid |-> !skip_r) else $error("unit inside discarded message");

  cover property (unit_valid && unit_base != spp_pkg::LVL_ROOT);
  cover property (err_pulse ##[1:40] msg_done);
  cover property (unit_valid && msg_done);
endmodule : spp_parser_properties

// [dv/spp_host_model.sv]
// Remote controller model: sends text messages byte by byte.
// Assumes the parser never stalls, so no ready is watched.
`timescale 1ns/100ps
module spp_host_model (
  // Clock
  input wire logic clk_sys,
  // Byte stream
  output logic in_valid,
  output logic [7:0] in_data
);
  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
  end

  // Idle gaps show the inverted byte, not the stale one
  task automatic put(input logic [7:0] b, input int gap);
    @(negedge clk_sys);
    in_valid = 1'b1;
    in_data = b;
    repeat (gap) begin
      @(negedge clk_sys);
      in_valid = 1'b0;
      in_data = ~b;
    end
  endtask : put

  task automatic send(input string s, input int gap, input bit nl);
    for (int i = 0; i < s.len(); i++) put(s[i], gap);
    if (nl) put(spp_pkg::CH_NL, gap);
    @(negedge clk_sys);
    in_valid = 1'b0;
    in_data = ~in_data;
  endtask : send
endmodule : spp_host_model

// [dv/testbench.sv]
// Self-checking bench for the program message parser.
// Assumes the controller model drives the byte stream on falling edges.
`timescale 1ns/100ps
module testbench;
  typedef struct {
    string m; string p0; logic [2:0] dep; logic [2:0] bas;
    logic q; logic c; string prm; logic er;
  } spp_row_t;
  localparam int NROW = 13;
  logic clk_sys, rst, in_valid, in_ready, unit_valid, unit_query, unit_common;
  logic unit_src_opt, err_pulse, err_flag, msg_done;
  logic [7:0] in_data;
  logic [2:0] unit_base, unit_depth;
  logic [575:0] unit_path;
  logic [127:0] unit_param, c_path, c_prm;
  logic [4:0] unit_param_len, c_len;
  logic [2:0] c_dep, c_bas;
  logic c_q, c_c, c_so;
  logic [287:0] c_full;
  int miscompares, n_checks, n_units, n_err, n_done, u0, e0, d0;
  spp_row_t rows[NROW] = '{
    '{"VOLT 5", "VOLT", 3'h1, 3'h0, 1'b0, 1'b0, "5", 1'b0},
    '{"meas:curr?", "MEAS", 3'h2, 3'h0, 1'b1, 1'b0, "", 1'b0},
    '{"OUTPut ON", "OUTPUT", 3'h1, 3'h0, 1'b0, 1'b0, "ON", 1'b0},
    '{"SOUR:VOLT 3", "VOLT", 3'h1, 3'h0, 1'b0, 1'b0, "3", 1'b0},
    '{"MEAS:VOLT?;CURR?", "MEAS", 3'h2, 3'h1, 1'b1, 1'b0, "", 1'b0},
    '{"CURR?", "CURR", 3'h1, 3'h0, 1'b1, 1'b0, "", 1'b0},
    '{"VOLT 5;:CURR:LEV 2", "CURR", 3'h2, 3'h0, 1'b0, 1'b0, "2", 1'b0},
    '{"VOL 5", "", 3'h0, 3'h0, 1'b0, 1'b0, "", 1'b1},
    '{"VOLT 1", "VOLT", 3'h1, 3'h0, 1'b0, 1'b0, "1", 1'b0},
    '{"VOLTA 5", "", 3'h0, 3'h0, 1'b0, 1'b0, "", 1'b1},
    '{"VOLT?:LEV 1", "", 3'h0, 3'h0, 1'b0, 1'b0, "", 1'b1},
    '{"*rst", "RST", 3'h1, 3'h0, 1'b0, 1'b1, "", 1'b0},
    '{":TrIg", "TRIG", 3'h1, 3'h0, 1'b0, 1'b0, "", 1'b0}
  };
  string rw[10] = '{"ABOR", "CAL", "DISP", "INIT", "LIST", "MEAS", "OUTP", "STAT", "SYST", "TRIG"};

  spp_parser uut (
    .clk_sys(clk_sys), .rst(rst), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .unit_valid(unit_valid), .unit_base(unit_base),
    .unit_depth(unit_depth), .unit_path(unit_path), .unit_query(unit_query),
    .unit_common(unit_common), .unit_src_opt(unit_src_opt), .unit_param(unit_param),
    .unit_param_len(unit_param_len), .err_pulse(err_pulse), .err_flag(err_flag),
    .msg_done(msg_done)
  );
  spp_host_model host (.clk_sys(clk_sys), .in_valid(in_valid), .in_data(in_data));

  function automatic logic [127:0] s2v(input string s);
    logic [127:0] v;
    v = '0;
    for (int i = 0; i < s.len(); i++) v = {v[119:0], s[i]};
    return v;
  endfunction : s2v

  task automatic chk(input bit ok, input string what);
    n_checks++;
    if (!ok) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Outputs are settled at the falling edge
  always @(negedge clk_sys) begin
    if (unit_valid === 1'b1) begin
      n_units++;
      c_path = {32'h0, unit_path[95:0]};
      c_full = unit_path[287:0];
      c_so = unit_src_opt;
      {c_dep, c_bas, c_q, c_c} = {unit_depth, unit_base, unit_query, unit_common};
      {c_prm, c_len} = {unit_param, unit_param_len};
    end
    if (err_pulse === 1'b1) n_err++;
    if (msg_done === 1'b1) n_done++;
  end

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    complete_run;
  end

  initial begin
    rst = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk(unit_valid === 1'b0 && err_flag === 1'b0 && msg_done === 1'b0 && in_ready === 1'b1,
      "reset state");
    rst = 1'b0;
    for (int i = 0; i < NROW; i++) begin
      {u0, e0} = {n_units, n_err};
      host.send(rows[i].m, i % 2, 1'b1);
      repeat (2) @(negedge clk_sys);
      if (rows[i].er) begin
        chk(n_err > e0 && n_units == u0 && err_flag === 1'b1, rows[i].m);
      end else begin
        chk(n_units > u0 && n_err == e0 && err_flag === 1'b0 && c_path === s2v(rows[i].p0)
          && c_dep === rows[i].dep && c_bas === rows[i].bas && c_q === rows[i].q
          && c_c === rows[i].c && c_prm === s2v(rows[i].prm)
          && c_len === 5'(rows[i].prm.len()), rows[i].m);
      end
    end
    foreach (rw[k]) begin
      e0 = n_err;
      host.send(rw[k], 1, 1'b1);
      repeat (2) @(negedge clk_sys);
      chk(n_err == e0 && c_path === s2v(rw[k]) && c_bas === 3'h0, rw[k]);
    end
    host.send("STAT:OPER:COND?;ENAB 16", 0, 1'b1);
    repeat (2) @(negedge clk_sys);
    chk(c_full === {96'(s2v("ENAB")), 96'(s2v("OPER")), 96'(s2v("STAT"))} && c_bas === 3'h2
      && c_dep === 3'h3 && c_prm === s2v("16") && c_so === 1'b0, "below parent");
    d0 = n_done;
    host.send("VOLT 7\r", 0, 1'b0);
    repeat (3) @(negedge clk_sys);
    chk(n_done == d0, "return ended message");
    host.send("", 0, 1'b1);
    repeat (2) @(negedge clk_sys);
    chk(n_done == d0 + 1 && c_prm === s2v("7") && c_len === 5'h1 && c_so === 1'b1,
      "newline end");
    // Reset in the middle of a discarded message
    host.send("MEAS:VOL:", 0, 1'b0);
    chk(err_flag === 1'b1, "error before reset");
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(unit_valid === 1'b0 && err_flag === 1'b0 && err_pulse === 1'b0, "mid reset");
    rst = 1'b0;
    u0 = n_units;
    host.send("CURR?", 0, 1'b1);
    repeat (2) @(negedge clk_sys);
    chk(n_units == u0 + 1 && c_bas === 3'h0 && c_dep === 3'h1 && c_path === s2v("CURR")
      && c_q === 1'b1, "root after reset");
    complete_run;
  end
endmodule : testbench

bind spp_parser spp_parser_properties chk_i (
  .clk_sys(clk_sys), .rst(rst), .in_valid(in_valid), .in_data(in_data),
  .unit_valid(unit_valid), .unit_base(unit_base), .unit_depth(unit_depth),
  .unit_src_opt(unit_src_opt), .err_pulse(err_pulse), .err_flag(err_flag),
  .msg_done(msg_done)
);
